// file: rtl/msc_pkg.sv
package msc_pkg;
	// Printed offsets are not all multiples of four, so each offset is kept
	// as a register index and the APB byte address is four times the index.
	localparam logic [15:0] IDX_DBG_ONE = 16'h4020;
	localparam logic [15:0] IDX_DBG_TWO = 16'h5322;
	localparam logic [15:0] IDX_LOCK = 16'h5324;
	localparam logic [15:0] IDX_RAMSZ = 16'h5326;
	localparam logic [15:0] IDX_VEC_LO = 16'h5328;
	localparam logic [15:0] IDX_VEC_HI = 16'h532a;
	localparam logic [15:0] IDX_PSR = 16'h532c;
	localparam int ADDR_W = 18;
	// Unlock key for the protected registers.
	localparam logic [15:0] LOCK_KEY = 16'h0096;
	// Field positions.
	localparam int POS_DBG_ONE = 1;
	localparam int POS_DBG_TWO = 0;
	localparam int POS_DBG_BASE = 8;
	localparam int POS_ACT_SIZE = 4;
	localparam int POS_IRQ_EN = 4;
	localparam int POS_CARRY = 3;
	localparam int POS_OVF = 2;
	localparam int POS_ZERO = 1;
	localparam int POS_NEG = 0;
	// Reset values and fixed field values.
	localparam logic [2:0] RST_RAM_SIZE = 3'h6;
	localparam logic [2:0] ACT_RAM_SIZE = 3'h6;
	localparam logic [7:0] RST_VEC_MID = 8'h80;
	localparam logic [7:0] RST_VEC_HIGH = 8'h00;
	// Debug base addresses chosen by the debug base select bit.
	localparam logic [23:0] DBG_BASE_ONE = 24'h000000;
	localparam logic [23:0] DBG_BASE_ZERO = 24'hfffc00;

	// Live processor status, grouped.
	typedef struct packed {
		logic [2:0] irqLevel;
		logic irqEnable;
		logic carry;
		logic overflow;
		logic zero;
		logic negative;
	} msc_psr_t;

	// All state of the register bank.
	typedef struct packed {
		logic debugRunOne;
		logic debugRunTwo;
		logic [15:0] lockKey;
		logic debugBaseSel;
		logic [2:0] ramSizeSel;
		logic [7:0] vecMid;
		logic [7:0] vecHigh;
		msc_psr_t psr;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic unlocked;
		logic [23:0] debugBase;
	} msc_state_t;
endpackage : msc_pkg

// file: rtl/msc_regs.sv
// Local design decision: the APB register port.
`timescale 1ns/1ns
// Overview of operation
// - Register one bit 1 selects run (1) or stop (0) in debug; resets 0.
// - Register two bit 0 run/stop for non-peripheral-clock circuits; reset 0.
// - Writing 0x96 to lock key unlocks later registers; other values relock.
// - RAM size bit 8 picks debug base 0x0 (1) or 0xfffc00 (0).
// - RAM size select resets to 6; bits 6..4 always read actual size 6.
// - Vector base bits 7..0 are read-only zero.
// - Vector base bits 15..8 are read/write, reset 0x80.
// - Vector base bits 23..16 read/write in high register, reset 0.
// - Status mirror shows live interrupt level, read-only, reset 0.
// - Status mirror bit 4 shows interrupt enable, read-only, reset 0.
// - Status mirror bits 3..0 show carry, overflow, zero, negative.
module msc_regs
	import msc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire msc_psr_t cpuStatus,
	output logic debugRunOne,
	output logic debugRunTwo,
	output logic [2:0] ramSizeSel,
	output logic [23:0] debugBase,
	output logic [23:0] vectorBase,
	output logic unlocked
);
	msc_state_t state_reg;
	msc_state_t state_next;
	logic [15:0] regIdx;
	logic aligned;
	logic setupRd;
	logic setupWr;
	logic accWr;
	logic lowLane;
	logic highLane;

	// Address decode: word index from the byte address.
	assign regIdx = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign setupRd = psel && !penable && !pwrite;
	assign setupWr = psel && !penable && pwrite;
	assign accWr = psel && penable && pwrite && state_reg.pready;
	assign lowLane = pstrb[0];
	assign highLane = pstrb[1];

	// Read data is prepared in the setup cycle so the access phase answers
	// with pready high in its first cycle; every transfer has no wait state.
	always_comb begin
		state_next = state_reg;
		state_next.pready = setupRd || setupWr;
		state_next.pslverr = 1'b0;
		if (setupRd || setupWr) begin
			state_next.prdata = 32'h0;
			if (!aligned) begin
				state_next.pslverr = 1'b1;
			end else begin
				unique case (regIdx)
					IDX_DBG_ONE: begin
						state_next.prdata[POS_DBG_ONE] = state_reg.debugRunOne;
					end
					IDX_DBG_TWO: begin
						state_next.prdata[POS_DBG_TWO] = state_reg.debugRunTwo;
					end
					IDX_LOCK: begin
						state_next.prdata[15:0] = state_reg.lockKey;
					end
					IDX_RAMSZ: begin
						state_next.prdata[POS_DBG_BASE] = state_reg.debugBaseSel;
						state_next.prdata[POS_ACT_SIZE +: 3] = ACT_RAM_SIZE;
						state_next.prdata[2:0] = state_reg.ramSizeSel;
					end
					IDX_VEC_LO: begin
						state_next.prdata[15:8] = state_reg.vecMid;
						state_next.prdata[7:0] = 8'h00;
					end
					IDX_VEC_HI: begin
						state_next.prdata[7:0] = state_reg.vecHigh;
					end
					IDX_PSR: begin
						// A read shows the status as it was two cycles before its access edge.
						state_next.prdata[POS_ZERO] = state_reg.psr.zero;
						state_next.prdata[POS_NEG] = state_reg.psr.negative;
						state_next.prdata[POS_CARRY] = state_reg.psr.carry;
						state_next.prdata[POS_OVF] = state_reg.psr.overflow;
						state_next.prdata[POS_IRQ_EN] = state_reg.psr.irqEnable;
						state_next.prdata[7:5] = state_reg.psr.irqLevel;
					end
					default: begin
						// Unmapped word: reads zero and flags an error.
						state_next.pslverr = 1'b1;
					end
				endcase
			end
		end
		// Writes take effect on the access edge with pready high.
		if (accWr && !state_reg.pslverr) begin
			unique case (regIdx)
				IDX_DBG_ONE: begin
					if (lowLane) begin
						state_next.debugRunOne = pwdata[POS_DBG_ONE];
					end
				end
				IDX_DBG_TWO: begin
					if (lowLane) begin
						state_next.debugRunTwo = pwdata[POS_DBG_TWO];
					end
				end
				IDX_LOCK: begin
					// A partial write changes only its byte lanes; the merged key decides the lock.
					if (lowLane) begin
						state_next.lockKey[7:0] = pwdata[7:0];
					end
					if (highLane) begin
						state_next.lockKey[15:8] = pwdata[15:8];
					end
				end
				IDX_RAMSZ: begin
					if (state_reg.unlocked) begin
						if (highLane) begin
							state_next.debugBaseSel = pwdata[POS_DBG_BASE];
						end
						if (lowLane) begin
							state_next.ramSizeSel = pwdata[2:0];
						end
					end
				end
				IDX_VEC_LO: begin
					if (state_reg.unlocked && highLane) begin
						state_next.vecMid = pwdata[15:8];
					end
				end
				IDX_VEC_HI: begin
					if (state_reg.unlocked && lowLane) begin
						state_next.vecHigh = pwdata[7:0];
					end
				end
				default: begin
					// Status mirror and unmapped words ignore writes.
				end
			endcase
		end
		state_next.unlocked = (state_next.lockKey == LOCK_KEY);
		state_next.psr = cpuStatus;
		state_next.debugBase = state_next.debugBaseSel ?
			DBG_BASE_ONE : DBG_BASE_ZERO;
	end

	// Single state register; every field returns to its documented reset.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
			state_reg.ramSizeSel <= RST_RAM_SIZE;
			state_reg.vecMid <= RST_VEC_MID;
			state_reg.vecHigh <= RST_VEC_HIGH;
			state_reg.debugBase <= DBG_BASE_ZERO;
		end else begin
			state_reg <= state_next;
		end
	end

	// All outputs come straight from state flip-flops, except vectorBase bits 7..0, which are tied to zero.
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign debugRunOne = state_reg.debugRunOne;
	assign debugRunTwo = state_reg.debugRunTwo;
	assign ramSizeSel = state_reg.ramSizeSel;
	assign debugBase = state_reg.debugBase;
	assign vectorBase = {state_reg.vecHigh, state_reg.vecMid, 8'h00};
	assign unlocked = state_reg.unlocked;
endmodule : msc_regs

// file: tb/msc_regs_chk.sv
`timescale 1ns/1ns
module msc_regs_chk
	import msc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire msc_psr_t cpuStatus,
	input wire logic debugRunOne,
	input wire logic [23:0] debugBase,
	input wire logic [23:0] vectorBase,
	input wire logic unlocked
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Access edge of a transfer, and of a write to one register index.
	sequence s_acc;
		psel && penable && pready;
	endsequence
	sequence s_wr(logic [15:0] i);
		s_acc ##0 pwrite && paddr == {i, 2'b00};
	endsequence
	a_ready_pulse: assert property (s_acc |=> !pready)
		else $error("pready held longer than one cycle");
	a_setup_answer: assert property (psel && !penable |=> pready)
		else $error("no answer in the first access cycle");
	a_unlock_key: assert property (s_wr(IDX_LOCK) ##0 pstrb == 4'hf
		|=> unlocked == ($past(pwdata[15:0]) == LOCK_KEY))
		else $error("unlock state does not follow the key");
	a_locked_hold: assert property (s_wr(IDX_VEC_HI) ##0 !unlocked
		|=> $stable(vectorBase)) else $error("locked write took effect");
	a_run_write: assert property (s_wr(IDX_DBG_ONE) ##0 pstrb[0]
		|=> debugRunOne == $past(pwdata[1])) else $error("run bit wrong");
	a_base_map: assert property (debugBase == DBG_BASE_ONE
		|| debugBase == DBG_BASE_ZERO) else $error("debug base invalid");
	a_vector_align: assert property (vectorBase[7:0] == 8'h00)
		else $error("vector base low byte not zero");
	a_psr_mirror: assert property (s_acc ##0 !pwrite
		&& paddr == {IDX_PSR, 2'b00} |-> prdata == {24'h0, $past(cpuStatus, 2)})
		else $error("status mirror read wrong");
endmodule : msc_regs_chk

bind msc_regs msc_regs_chk chk_i (.*);

// file: tb/test_misc_system_control_regs.sv
`timescale 1ns/1ns
module test_misc_system_control_regs
	import msc_pkg::*;
;
	typedef struct packed {logic w; logic [15:0] i, d, e; logic r;} msc_row_t;
	logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, debugRunOne, debugRunTwo, unlocked;
	logic [2:0] ramSizeSel;
	logic [23:0] debugBase, vectorBase;
	msc_psr_t cpuStatus = '0;
	int failures = 0;
	int samples_checked = 0;
	// Each row: optional write of d, then a read that must give e and r.
	msc_row_t rows [18] = '{{1'b0, IDX_DBG_ONE, 16'h0, 16'h0000, 1'b0},
		{1'b0, IDX_DBG_TWO, 16'h0, 16'h0000, 1'b0},
		{1'b0, IDX_LOCK, 16'h0, 16'h0000, 1'b0},
		{1'b0, IDX_RAMSZ, 16'h0, 16'h0066, 1'b0},
		{1'b0, IDX_VEC_LO, 16'h0, 16'h8000, 1'b0},
		{1'b0, IDX_VEC_HI, 16'h0, 16'h0000, 1'b0},
		{1'b0, IDX_PSR, 16'h0, 16'h0000, 1'b0},
		{1'b1, IDX_RAMSZ, 16'h0101, 16'h0066, 1'b0},
		{1'b1, IDX_LOCK, 16'h0096, 16'h0096, 1'b0},
		{1'b1, IDX_RAMSZ, 16'hffff, 16'h0167, 1'b0},
		{1'b1, IDX_VEC_LO, 16'habcd, 16'hab00, 1'b0},
		{1'b1, IDX_VEC_HI, 16'hff12, 16'h0012, 1'b0},
		{1'b1, IDX_DBG_ONE, 16'hffff, 16'h0002, 1'b0},
		{1'b1, IDX_DBG_TWO, 16'hffff, 16'h0001, 1'b0},
		{1'b1, IDX_PSR, 16'hffff, 16'h0000, 1'b0},
		{1'b1, IDX_LOCK, 16'h0011, 16'h0011, 1'b0},
		{1'b1, IDX_VEC_HI, 16'h0034, 16'h0012, 1'b0},
		{1'b0, 16'h5330, 16'h0, 16'h0000, 1'b1}};

	msc_regs dut (.*);

	initial forever #20 clk_sys = ~clk_sys;

	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// One APB transfer; waits on pready, so no wait-state count is assumed.
	task apb(input logic w, input logic [15:0] i, input logic [15:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {16'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task end_sim;
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// Reset values, the row table, then outputs and the live status mirror.
	initial begin
		repeat (20) @(posedge clk_sys);
		chk("reset base", {8'h0, debugBase}, 32'hfffc00);
		chk("reset vector", {8'h0, vectorBase}, 32'h8000);
		rstn <= 1'b1;
		foreach (rows[k]) begin
			if (rows[k].w)
				apb(1'b1, rows[k].i, rows[k].d);
			apb(1'b0, rows[k].i, 16'h0);
			chk("read", rd, {16'h0, rows[k].e});
			chk("error", {31'h0, err}, {31'h0, rows[k].r});
		end
		chk("base", {8'h0, debugBase}, 32'h0);
		chk("vector", {8'h0, vectorBase}, 32'h12ab00);
		chk("runs", {debugRunOne, debugRunTwo, ramSizeSel}, 5'h1f);
		cpuStatus <= 8'hb5;
		apb(1'b0, IDX_PSR, 16'h0);
		chk("status", rd, 32'hb5);
		// Mid-run reset from an unlocked state must clear the key and restore the run,
		// size and base reset values, and the bus must answer again right after it.
		apb(1'b1, IDX_LOCK, 16'h0096);
		@(posedge clk_sys);
		chk("unlock", {31'h0, unlocked}, 32'h1);
		rstn <= 1'b0;
		@(posedge clk_sys);
		chk("unlock reset", {31'h0, unlocked}, 32'h0);
		chk("run reset", {debugRunOne, debugRunTwo}, 2'h0);
		chk("size reset", {29'h0, ramSizeSel}, 32'h6);
		chk("base reset", {8'h0, debugBase}, 32'hfffc00);
		rstn <= 1'b1;
		apb(1'b0, IDX_RAMSZ, 16'h0);
		chk("read after reset", rd, 32'h66);
		end_sim();
	end

	// A hang ends the run as a failure well past the expected length.
	initial begin
		#100000;
		failures++;
		end_sim();
	end
endmodule : test_misc_system_control_regs
